/* src/i2b_cfg.svh */
`ifndef I2B_CFG_SVH
`define I2B_CFG_SVH
// What this block does
// - Sole master: drives clock, START, STOP
// - Direction decides who transmits and receives
// - Up to 626 kbit/s at n=1, above the fast-mode 400; seven-bit target addresses
// - Bus clock is 626 kHz over n
// - Divisor n loaded from each command
// - No extensions: no ten-bit, no high-speed
// - Bytes pass through untouched

// Core clock and bus clock base, in kHz
`define I2B_CLK_KHZ 10000
`define I2B_BASE_KHZ 626
// Quarter phases per bus clock period
`define I2B_PHASES 4
// Highest fast-mode bit rate, kbit/s
`define I2B_FAST_KBPS 400
// Largest divisor n
`define I2B_DIV_MAX 256
// Write data buffer
`define I2B_FIFO_DEPTH 16
`define I2B_DATA_W 8
`define I2B_ADDR_W 7
// Bit index of the acknowledge slot in a byte
`define I2B_ACK_BIT 4'h8
`define I2B_LAST_BIT 4'h7
`endif

/* src/i2b_pkg.sv */
package i2b_pkg;
  // Transfer sequencer states
  typedef enum logic [2:0] {
    I2B_IDLE = 3'h0,
    I2B_START = 3'h1,
    I2B_ADDR = 3'h2,
    I2B_WR = 3'h3,
    I2B_RD = 3'h4,
    I2B_STOP = 3'h5
  } i2b_state_e;

  // Completion status of a command
  typedef enum logic [1:0] {
    I2B_ST_OK = 2'h0,
    I2B_ST_ADDR_NACK = 2'h1,
    I2B_ST_DATA_NACK = 2'h2
  } i2b_status_e;

  typedef logic [7:0] i2b_byte_t;
endpackage

/* src/i2b_stream_if.sv */
`timescale 1ns/1ps
// Valid/ready byte stream between the bridge and its buffer
interface i2b_stream_if #(
  parameter int W = 8
);
  logic valid;
  logic [W-1:0] data;
  logic ready;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* src/i2b_fifo.sv */
`timescale 1ns/1ps
module i2b_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  i2b_stream_if.snk up,
  i2b_stream_if.src dn
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic rdy_q;
  logic ov_q;
  logic [W-1:0] od_q;

  // Push and pop qualifiers
  wire push = up.valid && rdy_q;
  wire load = (cnt_q != '0) && (!ov_q || dn.ready);
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load);

  // Ports come straight from flops
  assign up.ready = rdy_q;
  assign dn.valid = ov_q;
  assign dn.data = od_q;

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= up.data;
    end
  end

  // Pointers, fill level and ready
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
    end else begin
      wp_q <= push ? wp_q + 1'b1 : wp_q;
      rp_q <= load ? rp_q + 1'b1 : rp_q;
      cnt_q <= cnt_d;
      rdy_q <= int'(cnt_d) < DEPTH;
    end
  end

  // Registered read port
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ov_q <= 1'b0;
      od_q <= '0;
    end else if (load) begin
      ov_q <= 1'b1;
      od_q <= mem_q[rp_q];
    end else if (dn.ready) begin
      ov_q <= 1'b0;
    end
  end
endmodule // i2b_fifo

/* src/i2b_bridge.sv */
`timescale 1ns/1ps
`include "i2b_cfg.svh"
module i2b_bridge
  import i2b_pkg::*;
#(
  parameter int DEPTH = `I2B_FIFO_DEPTH,
  parameter int DW = `I2B_DATA_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [`I2B_ADDR_W-1:0] cmd_addr,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_len,
  input wire logic [7:0] cmd_div_m1,
  input wire logic wdat_valid,
  output logic wdat_ready,
  input wire logic [DW-1:0] wdat,
  output logic rdat_valid,
  output logic [DW-1:0] rdat,
  output logic done,
  output logic [1:0] status,
  output logic busy,
  input wire logic scl_line,
  output logic scl_val,
  output logic scl_en,
  input wire logic sda_line,
  output logic sda_val,
  output logic sda_en
);
  // Phase step derived from base rate and core clock
  localparam int STEP = `I2B_BASE_KHZ * `I2B_PHASES;
  localparam logic [14:0] STEP_W = 15'(STEP);
  localparam logic [14:0] MOD_W = 15'(`I2B_CLK_KHZ);

  i2b_state_e state_q;
  i2b_state_e state_d;
  i2b_status_e status_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] len_q;
  logic [`I2B_ADDR_W-1:0] addr_q;
  logic rnw_q;
  logic [7:0] div_q;
  logic [7:0] div_cnt_q;
  logic [14:0] acc_q;
  logic samp_q;
  logic [7:0] drain_q;
  logic [7:0] drain_d;
  logic scl_en_q;
  logic sda_en_q;
  logic line_val_q;
  logic cmd_ready_q;
  logic rdat_valid_q;
  logic [DW-1:0] rdat_q;
  logic done_q;
  logic busy_q;

  // Write data buffer in front of the sequencer
  i2b_stream_if #(.W(DW)) fin ();
  i2b_stream_if #(.W(DW)) fout ();
  assign fin.valid = wdat_valid;
  assign fin.data = wdat;
  assign wdat_ready = fin.ready;

  i2b_fifo #(.W(DW), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .up(fin.snk),
    .dn(fout.src)
  );

  // Fractional base tick and divide-by-n phase tick
  wire run = state_q != I2B_IDLE;
  wire [14:0] acc_sum = acc_q + STEP_W;
  wire base_tick = acc_sum >= MOD_W;
  wire [14:0] acc_d = base_tick ? acc_sum - MOD_W : acc_sum;
  wire ph_tick = run && base_tick && (div_cnt_q == div_q);

  // Bit and byte position decode
  wire end_bit = ph_q == 2'h3;
  wire ack_bit = bit_q == `I2B_ACK_BIT;
  wire byte_end = end_bit && ack_bit;
  wire nack = samp_q;
  wire st_addr = state_q == I2B_ADDR;
  wire st_wr = state_q == I2B_WR;
  wire st_rd = state_q == I2B_RD;
  wire last_byte = len_q == 8'h1;

  // Next write byte needed from the buffer
  wire addr_go_wr = st_addr && !nack && (len_q != 8'h0) && !rnw_q;
  wire wr_more = st_wr && !nack && !last_byte;
  wire need_byte = byte_end && (addr_go_wr || wr_more);

  // Hold phase while buffer is empty or a target stretches the clock
  wire stall = (need_byte && !fout.valid) || (ph_q == 2'h1 && !scl_line);
  wire adv = ph_tick && !stall;
  wire take = cmd_valid && cmd_ready_q;
  wire drain_pop = !run && (drain_q != 8'h0) && fout.valid;
  wire pop = (adv && need_byte) || drain_pop;
  assign fout.ready = pop;

  // Missing acknowledge decode, leftover write bytes discarded later
  wire addr_nack = adv && byte_end && st_addr && nack;
  wire wr_nack = adv && byte_end && st_wr && nack;
  assign drain_d = (addr_nack && !rnw_q) ? len_q :
                   wr_nack ? len_q - 8'h1 :
                   drain_pop ? drain_q - 8'h1 : drain_q;

  // Line drive per state and phase; enable high pulls the line low
  wire data_st = st_addr || st_wr || st_rd;
  wire scl_drv = (state_q == I2B_START) ? (ph_q == 2'h3) :
                 (state_q == I2B_STOP) ? (ph_q == 2'h0) :
                 data_st ? (ph_q == 2'h0 || ph_q == 2'h3) : 1'b0;
  wire tx_drv = ack_bit ? 1'b0 : ~sh_q[7];
  wire rx_drv = ack_bit && !last_byte;
  wire sda_drv = (state_q == I2B_START) ? (ph_q != 2'h0) :
                 (state_q == I2B_STOP) ? (ph_q < 2'h2) :
                 (st_addr || st_wr) ? tx_drv :
                 st_rd ? rx_drv : 1'b0;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      I2B_IDLE: begin
        if (take) begin
          state_d = I2B_START;
        end
      end
      I2B_START: begin
        if (adv && end_bit) begin
          state_d = I2B_ADDR;
        end
      end
      I2B_ADDR: begin
        if (adv && byte_end) begin
          state_d = (nack || len_q == 8'h0) ? I2B_STOP : (rnw_q ? I2B_RD : I2B_WR);
        end
      end
      I2B_WR: begin
        if (adv && byte_end) begin
          state_d = (nack || last_byte) ? I2B_STOP : I2B_WR;
        end
      end
      I2B_RD: begin
        if (adv && byte_end) begin
          state_d = last_byte ? I2B_STOP : I2B_RD;
        end
      end
      I2B_STOP: begin
        if (adv && end_bit) begin
          state_d = I2B_IDLE;
        end
      end
      default: state_d = I2B_IDLE;
    endcase
  end

  // State, phase and divider counters
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= I2B_IDLE;
      ph_q <= 2'h0;
      acc_q <= 15'h0;
      div_cnt_q <= 8'h0;
    end else begin
      state_q <= state_d;
      ph_q <= !run ? 2'h0 : (adv ? ph_q + 2'h1 : ph_q);
      acc_q <= acc_d;
      div_cnt_q <= (!run || ph_tick) ? 8'h0 : (base_tick ? div_cnt_q + 8'h1 : div_cnt_q);
    end
  end

  // Command capture, divisor reloaded per command
  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_q <= '0;
      rnw_q <= 1'b0;
      div_q <= 8'hff;
    end else if (take) begin
      addr_q <= cmd_addr;
      rnw_q <= cmd_read;
      div_q <= cmd_div_m1;
    end
  end

  // Remaining byte count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      len_q <= 8'h0;
    end else if (take) begin
      len_q <= cmd_len;
    end else if (adv && byte_end && (st_wr || st_rd)) begin
      len_q <= len_q - 8'h1;
    end
  end

  // Shift register and bit counter; bytes move unaltered
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sh_q <= 8'h0;
      bit_q <= 4'h0;
    end else if (adv && state_q == I2B_START && end_bit) begin
      sh_q <= {addr_q, rnw_q};
      bit_q <= 4'h0;
    end else if (adv && byte_end) begin
      sh_q <= pop ? fout.data : sh_q;
      bit_q <= 4'h0;
    end else if (adv && end_bit && data_st) begin
      sh_q <= st_rd ? sh_q : {sh_q[6:0], 1'b0};
      bit_q <= bit_q + 4'h1;
    end else if (adv && ph_q == 2'h1 && st_rd && !ack_bit) begin
      sh_q <= {sh_q[6:0], sda_line};
    end
  end

  // Line sample while clock is high
  always_ff @(posedge clk) begin
    if (!rstn) begin
      samp_q <= 1'b0;
    end else if (adv && ph_q == 2'h1) begin
      samp_q <= sda_line;
    end
  end

  // Pin drive flops
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_en_q <= 1'b0;
      sda_en_q <= 1'b0;
      line_val_q <= 1'b0;
    end else begin
      scl_en_q <= scl_drv;
      sda_en_q <= sda_drv;
      line_val_q <= 1'b0;
    end
  end

  // Read data out, one pulse per byte
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdat_valid_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      rdat_valid_q <= adv && end_bit && st_rd && bit_q == `I2B_LAST_BIT;
      if (adv && end_bit && st_rd && bit_q == `I2B_LAST_BIT) begin
        rdat_q <= sh_q;
      end
    end
  end

  // Status, completion and handshake
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_q <= I2B_ST_OK;
      drain_q <= 8'h0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      cmd_ready_q <= 1'b0;
    end else begin
      status_q <= take ? I2B_ST_OK : addr_nack ? I2B_ST_ADDR_NACK :
                  wr_nack ? I2B_ST_DATA_NACK : status_q;
      drain_q <= drain_d;
      done_q <= adv && end_bit && state_q == I2B_STOP;
      busy_q <= state_d != I2B_IDLE;
      cmd_ready_q <= !run && !take && drain_d == 8'h0;
    end
  end

  assign cmd_ready = cmd_ready_q;
  assign rdat_valid = rdat_valid_q;
  assign rdat = rdat_q;
  assign done = done_q;
  assign status = status_q;
  assign busy = busy_q;
  assign scl_val = line_val_q;
  assign sda_val = line_val_q;
  assign scl_en = scl_en_q;
  assign sda_en = sda_en_q;

  // Cycles between phase ticks, and unstalled cycles spent in STOP
  logic [11:0] gap_q;
  logic gap_ok_q;
  logic [12:0] stop_cnt_q;
  always_ff @(posedge clk) begin
    if (!rstn || !run) begin
      gap_q <= 12'h0;
      gap_ok_q <= 1'b0;
      stop_cnt_q <= 13'h0;
    end else begin
      gap_q <= ph_tick ? 12'h1 : gap_q + 12'h1;
      gap_ok_q <= gap_ok_q || ph_tick;
      stop_cnt_q <= (state_q != I2B_STOP) ? 13'h0 : stop_cnt_q + 13'(!stall);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // In START, data falls only while the clock line is released
  a_start_cond: assert property (
    (state_q == I2B_START && $rose(sda_en_q)) |-> !scl_en_q)
    else $error("START data edge while clock held low");
  a_stop_release: assert property (
    (state_q == I2B_STOP && $fell(sda_en_q)) |-> (!scl_en_q && $past(!scl_en_q)))
    else $error("STOP data release while clock held low");
  a_rd_no_drive: assert property (
    (st_rd && !ack_bit && $stable(bit_q) && $stable(state_q)) |-> !sda_en_q)
    else $error("Bridge drives data while target transmits");
  a_addr_byte: assert property (
    (st_addr && $past(state_q) == I2B_START) |-> sh_q == {addr_q, rnw_q})
    else $error("Address byte not seven bits plus direction");
  a_phase_gap: assert property (
    (ph_tick && gap_ok_q) |->
      (gap_q >= 12'(3 * (int'(div_q) + 1)) && gap_q <= 12'(4 * (int'(div_q) + 1))))
    else $error("Phase spacing does not match divisor");
  a_div_load: assert property (
    take |=> (div_q == $past(cmd_div_m1)) ##1 (div_q == $past(cmd_div_m1, 2)))
    else $error("Divisor not taken from command");
  a_no_restart: assert property (
    (state_q == I2B_STOP) |=> (state_q == I2B_STOP || state_q == I2B_IDLE))
    else $error("Repeated start after STOP");
  a_rd_pass: assert property (
    rdat_valid_q |-> (rdat_q == sh_q && $past(st_rd)))
    else $error("Read byte altered on the way out");
  a_nack_stop: assert property (
    addr_nack |=> (state_q == I2B_STOP && status_q == I2B_ST_ADDR_NACK))
    else $error("Address NACK not ended by STOP");
  // Four slowest phases bound the STOP, clock stretch excluded
  a_stop_bound: assert property (
    stop_cnt_q <= 13'h1068)
    else $error("STOP condition not finished in time");

  c_write_ok: cover property (done_q && status_q == I2B_ST_OK && !rnw_q);
  c_read_ok: cover property (done_q && status_q == I2B_ST_OK && rnw_q);
  c_data_nack: cover property (done_q && status_q == I2B_ST_DATA_NACK);
  c_buf_stall: cover property (ph_tick && need_byte && !fout.valid);
endmodule // i2b_bridge

/* verif/i2b_tgt.sv */
`timescale 1ns/1ps
// Seven-bit bus target with write memory, read pattern and fault knobs
module i2b_tgt #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack_wr,
  input wire logic stretch,
  output logic sda_pull,
  output logic scl_hold
);
  logic [7:0] sh = 8'h00;
  logic sel = 1'b0;
  logic rw = 1'b0;
  int bitc = 0;
  int idx = 0;
  logic [7:0] mem[$];
  logic [7:0] rb;
  initial sda_pull = 1'b0;
  initial scl_hold = 1'b0;
  // Start condition restarts framing
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bitc = 0;
      idx = 0;
      sel = 1'b0;
    end
  end
  // Sample on rising clock; master NACK ends a read
  always @(posedge scl) begin
    if (bitc < 8)
      sh = {sh[6:0], sda};
    else if (sel && rw && idx > 0 && sda)
      sel = 1'b0;
    bitc = bitc + 1;
  end
  // Change data on falling clock: acknowledge or read bits
  always @(negedge scl) begin
    if (bitc == 9) begin
      bitc = 0;
      idx = idx + 1;
    end
    // Read pattern for the current byte, refreshed before use
    rb = 8'ha5 + 8'h13 * idx[7:0];
    if (bitc == 8 && idx == 0) begin
      sel = (sh[7:1] == ADDR);
      rw = sh[0];
      sda_pull = sel;
    end else if (bitc == 8 && sel && !rw) begin
      mem.push_back(sh);
      sda_pull = !nack_wr;
    end else if (sel && rw && idx > 0 && bitc < 8)
      sda_pull = !rb[7-bitc];
    else
      sda_pull = 1'b0;
  end
  // Stretch the low clock phase when asked
  always @(negedge scl) begin
    if (stretch) begin
      scl_hold = 1'b1;
      #3000 scl_hold = 1'b0;
    end
  end
endmodule // i2b_tgt

/* verif/i2c_bridge_master_bench.sv */
`timescale 1ns/1ps
module i2c_bridge_master_bench;
  import i2b_pkg::*;
  localparam logic [6:0] TA = 7'h2a;
  logic clk, rstn, cmd_valid, cmd_read, wdat_valid, nack_wr, stretch, cap;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_len, cmd_div_m1, wdat, rdat;
  logic cmd_ready, wdat_ready, rdat_valid, done, busy;
  logic scl_val, scl_en, sda_val, sda_en, sda_pull, scl_hold;
  logic [1:0] status;
  wire scl;
  wire sda;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int starts = 0;
  int stops = 0;
  logic [7:0] rq[$];
  realtime tq[$];
  // Open-drain lines with pull-ups
  assign scl = !(scl_en | scl_hold);
  assign sda = !(sda_en | sda_pull);
  i2b_bridge i2b_bridge_inst (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_read(cmd_read), .cmd_len(cmd_len),
    .cmd_div_m1(cmd_div_m1), .wdat_valid(wdat_valid), .wdat_ready(wdat_ready),
    .wdat(wdat), .rdat_valid(rdat_valid), .rdat(rdat), .done(done), .status(status),
    .busy(busy), .scl_line(scl), .scl_val(scl_val), .scl_en(scl_en), .sda_line(sda),
    .sda_val(sda_val), .sda_en(sda_en));
  i2b_tgt #(.ADDR(TA)) i2b_tgt_inst (.scl(scl), .sda(sda), .nack_wr(nack_wr),
    .stretch(stretch), .sda_pull(sda_pull), .scl_hold(scl_hold));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Wire monitors: framing conditions, clock edges, read bytes
  always @(negedge sda) if (scl === 1'b1) starts++;
  always @(posedge sda) if (scl === 1'b1) stops++;
  always @(posedge scl) if (cap) tq.push_back($realtime);
  always @(posedge clk) if (rdat_valid === 1'b1) rq.push_back(rdat);
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge clk);
    #1;
    wdat_valid = 1'b1;
    wdat = b;
    do @(posedge clk); while (wdat_ready !== 1'b1);
    #1;
    wdat_valid = 1'b0;
  endtask
  task automatic run(input logic [6:0] a, input logic rd, input logic [7:0] len,
                     input logic [7:0] dm1, input logic [1:0] st);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_addr = a;
    cmd_read = rd;
    cmd_len = len;
    cmd_div_m1 = dm1;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    #1;
    cmd_valid = 1'b0;
    chk("busy after take", {busy, cmd_ready}, 2'b10);
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 30000);
    #1;
    chk("done in time", n < 30000, 1'b1);
    chk("status", status, st);
    chk("stops vs starts", stops, starts);
  endtask
  task automatic t_reset;
    chk("idle outputs", {cmd_ready, wdat_ready, busy, done, scl_en, sda_en}, 6'h30);
    $display("test reset done");
  endtask
  task automatic t_write;
    push(8'h3c);
    push(8'hc3);
    push(8'h01);
    run(TA, 1'b0, 8'h03, 8'h00, 2'h0);
    chk("written bytes", {i2b_tgt_inst.mem[0], i2b_tgt_inst.mem[1], i2b_tgt_inst.mem[2]},
        24'h3cc301);
    chk("open drain values", {scl_val, sda_val}, 2'b00);
    $display("test write done");
  endtask
  task automatic t_read;
    rq.delete();
    run(TA, 1'b1, 8'h03, 8'h00, 2'h0);
    chk("read count", rq.size(), 3);
    for (int i = 0; i < 3; i++)
      chk("read byte", rq[i], 8'ha5 + 8'h13 * (i + 1));
    $display("test read done");
  endtask
  task automatic t_nack;
    push(8'h11);
    push(8'h22);
    run(7'h15, 1'b0, 8'h02, 8'h00, 2'h1);
    nack_wr = 1'b1;
    push(8'h33);
    push(8'h44);
    run(TA, 1'b0, 8'h02, 8'h00, 2'h2);
    nack_wr = 1'b0;
    push(8'h77);
    run(TA, 1'b0, 8'h01, 8'h00, 2'h0);
    chk("byte after discard", i2b_tgt_inst.mem[$], 8'h77);
    $display("test nack done");
  endtask
  task automatic t_rate;
    realtime d;
    realtime e;
    for (int m = 0; m < 3; m += 2) begin
      tq.delete();
      cap = 1'b1;
      run(TA, 1'b0, 8'h00, m[7:0], 2'h0);
      cap = 1'b0;
      d = tq[8] - tq[0];
      e = 8.0e6 / 626.0 * (m + 1);
      chk("clock period in band", (d > e - 300.0) && (d < e + 300.0), 1);
    end
    $display("test rate done");
  endtask
  task automatic t_fill;
    int k;
    k = 0;
    @(posedge clk);
    #1;
    wdat_valid = 1'b1;
    wdat = 8'h00;
    repeat (40) begin
      @(posedge clk);
      if (wdat_ready === 1'b1)
        k++;
      #1;
      wdat = k[7:0];
    end
    wdat_valid = 1'b0;
    chk("buffer capacity", k, 17);
    stretch = 1'b1;
    run(TA, 1'b0, k[7:0], 8'h00, 2'h0);
    stretch = 1'b0;
    for (int i = 0; i < 17; i++)
      chk("drained byte", i2b_tgt_inst.mem[i2b_tgt_inst.mem.size() - 17 + i], i);
    $display("test fill done");
  endtask
  task automatic conclude;
    $display("counts tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rstn, cmd_valid, cmd_read, wdat_valid, nack_wr, stretch, cap} = 7'h00;
    {cmd_addr, cmd_len, cmd_div_m1, wdat} = 31'h0;
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    // Forget line edges seen while the pins left the unknown state
    starts = 0;
    stops = 0;
    t_reset();
    t_write();
    t_read();
    t_nack();
    t_rate();
    t_fill();
    conclude();
  end
endmodule // i2c_bridge_master_bench
